// file: core/cmr_consts.vh
// Constants for the CAN message RAM with ECC
`ifndef CMR_CONSTS_VH
`define CMR_CONSTS_VH
// Message RAM size in 32-bit words (2 KB)
`define CMR_RAM_WORDS 512
// Byte address of the first and the last message RAM byte
`define CMR_RAM_FIRST 12'h400
`define CMR_RAM_LAST 12'hbff
// Register byte offsets
`define CMR_OFS_CTRL 12'h000
`define CMR_OFS_ECC_CTRL 12'h004
`define CMR_OFS_ECC_STAT 12'h008
`define CMR_OFS_TEF_CFG 12'h00c
`define CMR_OFS_TEF_UA 12'h010
`define CMR_OFS_FIFO_CFG 12'h100
`define CMR_OFS_FIFO_UA 12'h200
// Reset values
`define CMR_RST_CTRL 4'h1
`define CMR_RST_ECC_PAR 7'h00
// Bits of controller_config
`define CMR_CTRL_CFG 0
`define CMR_CTRL_TEF_EN 1
`define CMR_CTRL_TXQ_EN 2
`define CMR_CTRL_GW_ESI 3
// Fields of ecc_control
`define CMR_ECC_EN 0
`define CMR_ECC_PAR_LSB 8
// Fields of ecc status
`define CMR_STAT_SEC 0
`define CMR_STAT_DED 1
`define CMR_STAT_ADDR_LSB 16
// Fields of fifo_control and event_fifo_control
`define CMR_FC_DEP_LSB 0
`define CMR_FC_PL_LSB 5
`define CMR_FC_TX 8
`define CMR_FC_TS 9
`define CMR_TEF_TS 5
// Words of an object before payload or timestamp
`define CMR_HDR_WORDS 5'h02
`endif

// file: core/cmr_msg_ram.v
// Message RAM of a CAN FD controller with layout, allocation and SEC/DED ECC
// Notes on behaviour
// - 2 KB RAM holds every message object
// - Event objects first, only when event store enabled
// - Transmit queue next, only when enabled
// - Then FIFO1 to FIFO31 in ascending order
// - Counts and payload sizes set in configuration mode
// - User address shows next object per FIFO
// - Seven parity bits stored per data word
// - ECC on: encode writes, check every read
// - ECC off: store parity field, strip parity
// - Correct single errors, flag double errors
// - Identifier word: standard, extended, bit eleven
// - FD identifier bit eleven kept at bit 29
// - Word one: tag, ESI, FDF, BRS, RTR, IDE, DLC
// - Payload from word two, or word three after a timestamp, byte 0 lowest
// - Gateway mode ORs ESI with error passive
// - ESI one means error passive node
// - Receive word one carries filter hit index
// - Receive timestamp word only when enabled
// - Event object: two words plus optional timestamp
// - Receive BRS reports switched bit rate
// - Whole words, addresses wrap inside RAM
`timescale 1ns/100ps
`default_nettype none
`include "cmr_consts.vh"
module cmr_msg_ram #(
   parameter AW = 9
) (
   input wire i_clk,
   input wire i_rst,
   input wire [11:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_we,
   input wire i_re,
   output reg [31:0] o_rd_data,
   input wire i_err_passive,
   input wire i_rx_hdr,
   input wire [4:0] i_rx_fifo,
   input wire [4:0] i_rx_obj,
   input wire [29:0] i_rx_id,
   input wire [8:0] i_rx_flags,
   input wire [4:0] i_rx_filt,
   input wire [31:0] i_rx_ts,
   input wire i_rx_pl,
   input wire [3:0] i_rx_pl_idx,
   input wire [31:0] i_rx_pl_data,
   input wire i_tx_rd,
   input wire [4:0] i_tx_fifo,
   input wire [4:0] i_tx_obj,
   input wire [4:0] i_tx_word,
   output reg [31:0] o_tx_rdata,
   output reg o_tx_rvalid,
   output reg o_tx_esi,
   input wire i_tx_done,
   input wire [31:0] i_tx_ts,
   output reg o_eng_busy,
   output reg o_cfg_mode
);
   // Sequencer states
   localparam S_IDLE = 3'd0;
   localparam S_RX0 = 3'd1;
   localparam S_RX1 = 3'd2;
   localparam S_RX2 = 3'd3;
   localparam S_TE0 = 3'd4;
   localparam S_TE1 = 3'd5;
   localparam S_TE2 = 3'd6;

   // Payload size code to words
   function [4:0] cmr_pl_words;
      input [2:0] c;
      begin
         case (c)
            3'h0: cmr_pl_words = 5'h02;
            3'h1: cmr_pl_words = 5'h03;
            3'h2: cmr_pl_words = 5'h04;
            3'h3: cmr_pl_words = 5'h05;
            3'h4: cmr_pl_words = 5'h06;
            3'h5: cmr_pl_words = 5'h08;
            3'h6: cmr_pl_words = 5'h0c;
            default: cmr_pl_words = 5'h10;
         endcase
      end
   endfunction

   // Word address of word w of object o in an area; wraps in the RAM
   function [AW-1:0] cmr_obj_addr;
      input [AW-1:0] b;
      input [4:0] o;
      input [4:0] sz;
      input [4:0] w;
      reg [13:0] t;
      begin
         t = {5'h00, b} + ({9'h000, o} * {9'h000, sz}) + {9'h000, w};
         cmr_obj_addr = t[AW-1:0];
      end
   endfunction

   // Hamming parity: xor of code positions of set data bits, plus overall
   function [6:0] cmr_ecc_enc;
      input [31:0] d;
      integer p;
      integer j;
      reg [5:0] s;
      begin
         s = 6'h00;
         j = 0;
         for (p = 1; p < 39; p = p + 1)
            if ((p & (p - 1)) != 0)
            begin
               if (d[j])
                  s = s ^ p[5:0];
               j = j + 1;
            end
         cmr_ecc_enc = {(^d) ^ (^s), s};
      end
   endfunction

   // Decode: {double, single, corrected data}
   function [33:0] cmr_ecc_dec;
      input [38:0] w;
      integer p;
      integer j;
      reg [5:0] s;
      reg [31:0] d;
      reg ov;
      begin
         s = w[37:32];
         d = w[31:0];
         ov = ^w;
         j = 0;
         for (p = 1; p < 39; p = p + 1)
            if ((p & (p - 1)) != 0)
            begin
               if (w[j])
                  s = s ^ p[5:0];
               j = j + 1;
            end
         j = 0;
         for (p = 1; p < 39; p = p + 1)
            if ((p & (p - 1)) != 0)
            begin
               if (ov && (s == p[5:0]))
                  d[j] = ~d[j];
               j = j + 1;
            end
         cmr_ecc_dec = {(~ov) & (s != 6'h00), ov, d};
      end
   endfunction

   // Parity and data words of the message RAM
   reg [38:0] ram [0:`CMR_RAM_WORDS-1];
   // Control and configuration state
   reg [3:0] ctrl_r;
   reg ecc_en_r;
   reg [6:0] ecc_par_r;
   reg sec_r;
   reg ded_r;
   reg [AW-1:0] err_addr_r;
   reg [4:0] tef_dep_r;
   reg tef_ts_r;
   reg [4:0] tef_head_r;
   reg [4:0] f_dep_r [0:31];
   reg [2:0] f_pl_r [0:31];
   reg f_tx_r [0:31];
   reg f_ts_r [0:31];
   reg [4:0] f_head_r [0:31];
   // Sequencer state and latched operands
   reg [2:0] st_r;
   reg [2:0] st_nxt;
   reg [4:0] op_f_r;
   reg [4:0] op_o_r;
   reg [29:0] op_id_r;
   reg [8:0] op_flg_r;
   reg [4:0] op_filt_r;
   reg [31:0] op_ts_r;
   // Derived layout
   reg [AW-1:0] fbase [0:31];
   reg [4:0] fsize [0:31];
   reg [4:0] tef_sz;
   reg [13:0] acc;
   integer m;
   integer n;
   integer k;

   // Object sizes in words
   always @*
   begin
      tef_sz = `CMR_HDR_WORDS + {4'h0, tef_ts_r};
      for (m = 0; m < 32; m = m + 1)
         fsize[m] = `CMR_HDR_WORDS + {4'h0, f_ts_r[m] & ~f_tx_r[m]}
                    + cmr_pl_words(f_pl_r[m]);
   end

   // Area bases: event objects, then queue, then FIFO1..31
   always @*
   begin
      acc = 14'h0000;
      if (ctrl_r[`CMR_CTRL_TEF_EN])
         acc = {9'h000, tef_dep_r} * {9'h000, tef_sz} + {9'h000, tef_sz};
      // Own loop index so this process does not share a variable with the size process
      for (n = 0; n < 32; n = n + 1)
      begin
         fbase[n] = acc[AW-1:0];
         if ((n != 0) || ctrl_r[`CMR_CTRL_TXQ_EN])
            acc = acc + {9'h000, f_dep_r[n]} * {9'h000, fsize[n]}
                  + {9'h000, fsize[n]};
      end
   end

   // Host side decode
   wire [11:0] h_sub = i_addr - `CMR_RAM_FIRST;
   wire h_ram = (i_addr >= `CMR_RAM_FIRST) && (i_addr <= `CMR_RAM_LAST);
   wire [AW-1:0] h_idx = h_sub[AW+1:2];
   wire [4:0] h_sel = i_addr[6:2];
   wire h_cfg = (i_addr[11:7] == `CMR_OFS_FIFO_CFG >> 7);
   wire h_ua = (i_addr[11:7] == `CMR_OFS_FIFO_UA >> 7);
   wire cfg_ok = ctrl_r[`CMR_CTRL_CFG];
   wire [AW-1:0] ua_w = cmr_obj_addr(fbase[h_sel], f_head_r[h_sel], fsize[h_sel], 5'h00);
   wire [AW-1:0] tef_w = cmr_obj_addr({AW{1'b0}}, tef_head_r, tef_sz, 5'h00);

   // Host read decode of RAM word
   wire [38:0] h_raw = ram[h_idx];
   wire [33:0] h_dec = cmr_ecc_dec(h_raw);
   wire h_chk = i_re && h_ram && ecc_en_r;

   // Engine addressing
   reg [AW-1:0] e_ra;
   reg [AW-1:0] e_wa;
   reg [31:0] e_wd;
   reg e_we;
   wire [38:0] e_raw = ram[e_ra];
   wire [33:0] e_dec = cmr_ecc_dec(e_raw);
   wire [31:0] e_data = ecc_en_r ? e_dec[31:0] : e_raw[31:0];
   wire e_rd = i_tx_rd || (st_r == S_TE0) || (st_r == S_TE1);
   wire e_chk = e_rd && ecc_en_r;
   wire rx_ts = f_ts_r[op_f_r] & ~f_tx_r[op_f_r];
   wire rx_pl_ts = f_ts_r[i_rx_fifo] & ~f_tx_r[i_rx_fifo];

   // Engine read address and write port, per sequencer state
   always @*
   begin
      e_ra = cmr_obj_addr(fbase[i_tx_fifo], i_tx_obj, fsize[i_tx_fifo], i_tx_word);
      e_we = 1'b0;
      e_wa = {AW{1'b0}};
      e_wd = 32'h0000_0000;
      case (st_r)
         S_RX0:
         begin
            e_we = 1'b1;
            e_wa = cmr_obj_addr(fbase[op_f_r], op_o_r, fsize[op_f_r], 5'h00);
            e_wd = {2'b00, op_id_r};
         end
         S_RX1:
         begin
            e_we = 1'b1;
            e_wa = cmr_obj_addr(fbase[op_f_r], op_o_r, fsize[op_f_r], 5'h01);
            e_wd = {16'h0000, op_filt_r, 2'b00, op_flg_r};
         end
         S_RX2:
         begin
            e_we = 1'b1;
            e_wa = cmr_obj_addr(fbase[op_f_r], op_o_r, fsize[op_f_r], 5'h02);
            e_wd = op_ts_r;
         end
         S_TE0:
         begin
            e_ra = cmr_obj_addr(fbase[op_f_r], op_o_r, fsize[op_f_r], 5'h00);
            e_we = 1'b1;
            e_wa = tef_w;
            e_wd = {2'b00, e_data[29:0]};
         end
         S_TE1:
         begin
            e_ra = cmr_obj_addr(fbase[op_f_r], op_o_r, fsize[op_f_r], 5'h01);
            e_we = 1'b1;
            e_wa = cmr_obj_addr({AW{1'b0}}, tef_head_r, tef_sz, 5'h01);
            e_wd = {16'h0000, e_data[15:0]};
         end
         S_TE2:
         begin
            e_we = 1'b1;
            e_wa = cmr_obj_addr({AW{1'b0}}, tef_head_r, tef_sz, 5'h02);
            e_wd = op_ts_r;
         end
         default:
         begin
            if (i_rx_pl)
            begin
               // Payload words follow the header and optional timestamp
               e_we = 1'b1;
               e_wa = cmr_obj_addr(fbase[i_rx_fifo], i_rx_obj, fsize[i_rx_fifo],
                                   `CMR_HDR_WORDS + {4'h0, rx_pl_ts} + {1'b0, i_rx_pl_idx});
               e_wd = i_rx_pl_data;
            end
         end
      endcase
   end

   // Sequencer next state
   always @*
   begin
      st_nxt = S_IDLE;
      case (st_r)
         S_IDLE:
         begin
            if (i_rx_hdr)
               st_nxt = S_RX0;
            else if (i_tx_done && ctrl_r[`CMR_CTRL_TEF_EN])
               st_nxt = S_TE0;
         end
         S_RX0: st_nxt = S_RX1;
         S_RX1: st_nxt = rx_ts ? S_RX2 : S_IDLE;
         S_TE0: st_nxt = S_TE1;
         S_TE1: st_nxt = tef_ts_r ? S_TE2 : S_IDLE;
         default: st_nxt = S_IDLE;
      endcase
   end

   // RAM writes; host first, engine second so the engine wins a clash
   always @(posedge i_clk)
   begin
      if (i_we && h_ram)
         ram[h_idx] <= {ecc_en_r ? cmr_ecc_enc(i_wdata) : ecc_par_r, i_wdata};
      if (e_we)
         ram[e_wa] <= {ecc_en_r ? cmr_ecc_enc(e_wd) : ecc_par_r, e_wd};
   end

   // Registers, sequencer and engine outputs
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctrl_r <= `CMR_RST_CTRL;
         ecc_en_r <= 1'b0;
         ecc_par_r <= `CMR_RST_ECC_PAR;
         sec_r <= 1'b0;
         ded_r <= 1'b0;
         err_addr_r <= {AW{1'b0}};
         tef_dep_r <= 5'h00;
         tef_ts_r <= 1'b0;
         tef_head_r <= 5'h00;
         for (k = 0; k < 32; k = k + 1)
         begin
            f_dep_r[k] <= 5'h00;
            f_pl_r[k] <= 3'h0;
            f_tx_r[k] <= 1'b0;
            f_ts_r[k] <= 1'b0;
            f_head_r[k] <= 5'h00;
         end
         st_r <= S_IDLE;
         op_f_r <= 5'h00;
         op_o_r <= 5'h00;
         op_id_r <= 30'h0000_0000;
         op_flg_r <= 9'h000;
         op_filt_r <= 5'h00;
         op_ts_r <= 32'h0000_0000;
         o_rd_data <= 32'h0000_0000;
         o_tx_rdata <= 32'h0000_0000;
         o_tx_rvalid <= 1'b0;
         o_tx_esi <= 1'b0;
         o_eng_busy <= 1'b0;
         o_cfg_mode <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
         o_eng_busy <= (st_nxt != S_IDLE);
         o_cfg_mode <= ctrl_r[`CMR_CTRL_CFG];
         // Latch operands when a sequence starts
         if (st_r == S_IDLE)
         begin
            op_f_r <= i_rx_hdr ? i_rx_fifo : i_tx_fifo;
            op_o_r <= i_rx_hdr ? i_rx_obj : i_tx_obj;
            op_ts_r <= i_rx_hdr ? i_rx_ts : i_tx_ts;
            op_id_r <= i_rx_id;
            op_flg_r <= i_rx_flags;
            op_filt_r <= i_rx_filt;
         end
         // Event entry done: advance and wrap the event write pointer
         if (((st_r == S_TE1) && !tef_ts_r) || (st_r == S_TE2))
            tef_head_r <= (tef_head_r == tef_dep_r) ? 5'h00 : tef_head_r + 5'h01;
         // Transmit word reads, ESI with optional gateway OR
         o_tx_rvalid <= i_tx_rd;
         o_tx_rdata <= i_tx_rd ? e_data : 32'h0000_0000;
         if (i_tx_rd && (i_tx_word == 5'h01))
            o_tx_esi <= e_data[8] | (ctrl_r[`CMR_CTRL_GW_ESI] & i_err_passive);
         // Sticky error flags; a new event beats the clear
         if (i_we && (i_addr == `CMR_OFS_ECC_STAT))
         begin
            if (i_wdata[`CMR_STAT_SEC])
               sec_r <= 1'b0;
            if (i_wdata[`CMR_STAT_DED])
               ded_r <= 1'b0;
         end
         if (h_chk && (h_dec[32] || h_dec[33]))
            err_addr_r <= h_idx;
         else if (e_chk && (e_dec[32] || e_dec[33]))
            err_addr_r <= e_ra;
         if ((h_chk && h_dec[32]) || (e_chk && e_dec[32]))
            sec_r <= 1'b1;
         if ((h_chk && h_dec[33]) || (e_chk && e_dec[33]))
            ded_r <= 1'b1;
         // Register writes
         if (i_we)
         begin
            if (i_addr == `CMR_OFS_CTRL)
               ctrl_r <= i_wdata[3:0];
            if (i_addr == `CMR_OFS_ECC_CTRL)
            begin
               ecc_en_r <= i_wdata[`CMR_ECC_EN];
               ecc_par_r <= i_wdata[`CMR_ECC_PAR_LSB+6:`CMR_ECC_PAR_LSB];
            end
            if ((i_addr == `CMR_OFS_TEF_CFG) && cfg_ok)
            begin
               tef_dep_r <= i_wdata[4:0];
               tef_ts_r <= i_wdata[`CMR_TEF_TS];
               tef_head_r <= 5'h00;
            end
            if (h_cfg && cfg_ok)
            begin
               f_dep_r[h_sel] <= i_wdata[4:0];
               f_pl_r[h_sel] <= i_wdata[`CMR_FC_PL_LSB+2:`CMR_FC_PL_LSB];
               f_tx_r[h_sel] <= i_wdata[`CMR_FC_TX] | (h_sel == 5'h00);
               f_ts_r[h_sel] <= i_wdata[`CMR_FC_TS];
               f_head_r[h_sel] <= 5'h00;
            end
            // A write to a user address outside configuration mode steps to the next object
            if (h_ua && !cfg_ok)
               f_head_r[h_sel] <= (f_head_r[h_sel] == f_dep_r[h_sel]) ? 5'h00 :
                                  f_head_r[h_sel] + 5'h01;
         end
         // Read data valid only in the cycle after the strobe
         if (!i_re)
            o_rd_data <= 32'h0000_0000;
         else if (h_ram)
            o_rd_data <= ecc_en_r ? h_dec[31:0] : h_raw[31:0];
         else if (i_addr == `CMR_OFS_CTRL)
            o_rd_data <= {28'h0000_000, ctrl_r};
         else if (i_addr == `CMR_OFS_ECC_CTRL)
            o_rd_data <= {17'h00000, ecc_par_r, 7'h00, ecc_en_r};
         else if (i_addr == `CMR_OFS_ECC_STAT)
            o_rd_data <= {7'h00, err_addr_r, 14'h0000, ded_r, sec_r};
         else if (i_addr == `CMR_OFS_TEF_CFG)
            o_rd_data <= {26'h0000000, tef_ts_r, tef_dep_r};
         else if (i_addr == `CMR_OFS_TEF_UA)
            o_rd_data <= {20'h00000, `CMR_RAM_FIRST + {1'b0, tef_w, 2'b00}};
         else if (h_cfg)
            o_rd_data <= {22'h000000, f_ts_r[h_sel], f_tx_r[h_sel], f_pl_r[h_sel], f_dep_r[h_sel]};
         else if (h_ua)
            o_rd_data <= {20'h00000, `CMR_RAM_FIRST + {1'b0, ua_w, 2'b00}};
         else
            o_rd_data <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// file: testbench/cmr_msg_ram_props.sv
// Port-level assertions for the message RAM
`timescale 1ns/100ps
`default_nettype none
module cmr_msg_ram_chk #(
   parameter AW = 9
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   input wire logic [31:0] o_rd_data,
   input wire logic i_err_passive,
   input wire logic i_rx_hdr,
   input wire logic i_tx_rd,
   input wire logic [4:0] i_tx_word,
   input wire logic [31:0] o_tx_rdata,
   input wire logic o_tx_rvalid,
   input wire logic o_tx_esi,
   input wire logic o_eng_busy,
   input wire logic o_cfg_mode
);
   // Single clock domain, reset disables everything
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   read_slot_only_a: assert property (!$past(i_re) |-> o_rd_data == 32'h0)
      else $error("read data outside the read slot");
   fetch_answer_a: assert property (i_tx_rd && !o_eng_busy |=> o_tx_rvalid)
      else $error("transmit fetch not answered");
   fetch_cause_a: assert property (o_tx_rvalid |-> $past(i_tx_rd))
      else $error("transmit answer without fetch");
   fetch_quiet_a: assert property (!o_tx_rvalid |-> o_tx_rdata == 32'h0)
      else $error("transmit data outside answer");
   esi_plain_a: assert property (o_tx_rvalid && $past(i_tx_word) == 5'h01 && !$past(i_err_passive)
      |-> o_tx_esi == o_tx_rdata[8])
      else $error("esi differs from object bit");
   esi_hold_a: assert property (!(o_tx_rvalid && $past(i_tx_word) == 5'h01) |-> $stable(o_tx_esi))
      else $error("esi moved without word one fetch");
   hdr_busy_a: assert property (i_rx_hdr && !o_eng_busy |=> o_eng_busy)
      else $error("header store did not start");
   busy_span_a: assert property ($rose(o_eng_busy) |=> o_eng_busy ##[1:2] !o_eng_busy)
      else $error("sequencer run length wrong");
   cfg_cause_a: assert property ($changed(o_cfg_mode) |-> $past(i_we, 2) && $past(i_addr, 2) == 12'h000)
      else $error("config mode changed without write");
   cfg_leave_a: assert property (i_we && i_addr == 12'h000 && !i_wdata[0] |-> ##2 !o_cfg_mode)
      else $error("config mode not left");
endmodule

bind cmr_msg_ram cmr_msg_ram_chk #(.AW(AW)) chk_u (
   .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re),
   .o_rd_data(o_rd_data), .i_err_passive(i_err_passive), .i_rx_hdr(i_rx_hdr), .i_tx_rd(i_tx_rd),
   .i_tx_word(i_tx_word), .o_tx_rdata(o_tx_rdata), .o_tx_rvalid(o_tx_rvalid), .o_tx_esi(o_tx_esi),
   .o_eng_busy(o_eng_busy), .o_cfg_mode(o_cfg_mode));
`default_nettype wire

// file: testbench/cmr_eng_model.sv
// Behavioural protocol engine on the far side of the message RAM
`timescale 1ns/100ps
`default_nettype none
module cmr_eng_model (
   input wire logic i_clk,
   input wire logic [31:0] i_tx_rdata,
   input wire logic i_tx_rvalid,
   input wire logic i_tx_esi,
   output logic o_err_passive,
   output logic [3:0] o_stb,
   output logic [4:0] o_fifo,
   output logic [4:0] o_obj,
   output logic [4:0] o_word,
   output logic [29:0] o_id,
   output logic [8:0] o_flags,
   output logic [4:0] o_filt,
   output logic [31:0] o_data
);
   // Quiet lines at time zero
   initial
   begin
      o_err_passive = 1'b0;
      o_stb = 4'h0;
      {o_fifo, o_obj, o_word, o_id, o_flags, o_filt, o_data} = '0;
   end
   // One request for one edge; strobe bits are header, payload, fetch, event
   task automatic req(input logic [3:0] s, input logic [4:0] f, input logic [4:0] ob, input logic [4:0] w,
                      input logic [29:0] id, input logic [8:0] fl, input logic [4:0] fi, input logic [31:0] d);
      begin
         @(posedge i_clk);
         o_stb <= s;
         {o_fifo, o_obj, o_word, o_id, o_flags, o_filt, o_data} <= {f, ob, w, id, fl, fi, d};
         @(posedge i_clk);
         o_stb <= 4'h0;
         // Released qualifiers are scrambled so stale values cannot pass
         {o_fifo, o_obj, o_word, o_id, o_flags, o_filt, o_data} <= ~{f, ob, w, id, fl, fi, d};
      end
   endtask
   // Queue word fetch; the answer is taken one edge after the request
   task automatic tx_read(input logic [4:0] w, output logic [31:0] d, output logic v, output logic e);
      begin
         req(4'h4, 5'h00, 5'h00, w, 30'h0, 9'h0, 5'h0, 32'h0);
         @(posedge i_clk);
         d = i_tx_rdata;
         v = i_tx_rvalid;
         e = i_tx_esi;
      end
   endtask
   // Error passive level of the node
   task automatic set_passive(input logic p);
      begin
         @(posedge i_clk);
         o_err_passive <= p;
      end
   endtask
endmodule
`default_nettype wire

// file: testbench/cmr_msg_ram_tb_top.sv
// Self-checking bench for the message RAM
`timescale 1ns/100ps
`default_nettype none
`include "cmr_consts.vh"
module cmr_msg_ram_tb_top;
   localparam logic [31:0] ALL = 32'hffff_ffff; // Full compare mask
   logic i_clk; // 40 MHz clock
   logic i_rst; // Asynchronous reset
   logic [11:0] bus_addr; // Register bus
   logic [31:0] bus_wdata;
   logic bus_we;
   logic bus_re;
   logic [31:0] rd_data; // Design outputs
   logic [31:0] tx_rdata;
   logic tx_rvalid;
   logic tx_esi;
   logic busy;
   logic cfg_mode;
   logic passive; // Engine side lines
   logic [3:0] stb;
   logic [4:0] fifo;
   logic [4:0] obj;
   logic [4:0] word;
   logic [29:0] id;
   logic [8:0] flags;
   logic [4:0] filt;
   logic [31:0] data;
   int num_errors;
   int check_count;
   int m;
   // Parity-injection table: control, data, corrected data, status
   logic [31:0] e_par[3] = '{32'h100, 32'h0, 32'h0};
   logic [31:0] e_dat[3] = '{32'h0, 32'h1, 32'h3};
   logic [31:0] e_exp[3] = '{32'h0, 32'h0, 32'h3};
   logic [31:0] e_sta[3] = '{32'h0064_0001, 32'h0064_0001, 32'h0064_0002};

   cmr_msg_ram #(.AW(9)) dut_u (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(bus_addr), .i_wdata(bus_wdata), .i_we(bus_we), .i_re(bus_re),
      .o_rd_data(rd_data), .i_err_passive(passive), .i_rx_hdr(stb[0]), .i_rx_fifo(fifo), .i_rx_obj(obj),
      .i_rx_id(id), .i_rx_flags(flags), .i_rx_filt(filt), .i_rx_ts(data), .i_rx_pl(stb[1]),
      .i_rx_pl_idx(word[3:0]), .i_rx_pl_data(data), .i_tx_rd(stb[2]), .i_tx_fifo(fifo), .i_tx_obj(obj),
      .i_tx_word(word), .o_tx_rdata(tx_rdata), .o_tx_rvalid(tx_rvalid), .o_tx_esi(tx_esi),
      .i_tx_done(stb[3]), .i_tx_ts(data), .o_eng_busy(busy), .o_cfg_mode(cfg_mode));
   cmr_eng_model eng_u (
      .i_clk(i_clk), .i_tx_rdata(tx_rdata), .i_tx_rvalid(tx_rvalid), .i_tx_esi(tx_esi),
      .o_err_passive(passive), .o_stb(stb), .o_fifo(fifo), .o_obj(obj), .o_word(word), .o_id(id),
      .o_flags(flags), .o_filt(filt), .o_data(data));

   // Clock source
   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // Verdict and end of run
   task automatic tally_and_finish;
      begin
         if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      begin
         check_count++;
         if (got !== exp)
         begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
         end
      end
   endtask
   // One-cycle register write
   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      begin
         @(posedge i_clk);
         bus_addr <= a;
         bus_wdata <= d;
         bus_we <= 1'b1;
         @(posedge i_clk);
         bus_we <= 1'b0;
      end
   endtask
   // One-cycle read, data taken in the following cycle under a mask
   task automatic reg_rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] mk);
      begin
         @(posedge i_clk);
         bus_addr <= a;
         bus_re <= 1'b1;
         @(posedge i_clk);
         bus_re <= 1'b0;
         @(posedge i_clk);
         check(rd_data & mk, e & mk);
      end
   endtask
   // Bounded wait for the sequencer to go idle
   task automatic wait_idle;
      begin
         repeat (20)
         begin
            @(posedge i_clk);
            if (busy === 1'b0)
               return;
         end
         num_errors++;
         tally_and_finish;
      end
   endtask
   // Queue word fetch with expected data and indicator
   task automatic tx_chk(input logic [4:0] w, input logic [31:0] e, input logic [31:0] mk, input logic es);
      logic [31:0] d;
      logic v;
      logic s;
      begin
         eng_u.tx_read(w, d, v, s);
         check({31'h0, v}, 32'h1);
         check(d & mk, e & mk);
         check({31'h0, s}, {31'h0, es});
      end
   endtask

   // Main sequence
   initial
   begin
      i_rst = 1'b1;
      bus_addr = 12'h000;
      bus_wdata = 32'h0;
      bus_we = 1'b0;
      bus_re = 1'b0;
      num_errors = 0;
      check_count = 0;
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      check({31'h0, cfg_mode}, 32'h1);
      reg_rd(`CMR_OFS_CTRL, 32'h1, 32'hf);
      // Allocation: events 2x3 words, queue 1x4, FIFO1 2x5 with stamp, others 1x4
      reg_wr(`CMR_OFS_ECC_CTRL, 32'h1);
      reg_wr(`CMR_OFS_TEF_CFG, 32'h21);
      reg_wr(`CMR_OFS_FIFO_CFG, 32'h0);
      reg_wr(`CMR_OFS_FIFO_CFG + 12'h004, 32'h201);
      for (m = 2; m < 32; m++)
         reg_wr(`CMR_OFS_FIFO_CFG + 12'(4 * m), 32'h0);
      reg_wr(`CMR_OFS_CTRL, 32'h0);
      reg_rd(`CMR_OFS_FIFO_UA + 12'h004, 32'h400, ALL);
      reg_rd(`CMR_OFS_FIFO_UA + 12'h00c, 32'h438, ALL);
      reg_wr(`CMR_OFS_CTRL, 32'h1);
      reg_wr(`CMR_OFS_CTRL, 32'h7);
      reg_wr(`CMR_OFS_CTRL, 32'h6);
      reg_rd(`CMR_OFS_TEF_UA, 32'h400, ALL);
      reg_rd(`CMR_OFS_FIFO_UA, 32'h418, ALL);
      for (m = 1; m < 32; m++)
         reg_rd(`CMR_OFS_FIFO_UA + 12'(4 * m), (m == 1) ? 32'h428 : 32'h450 + 32'(16 * (m - 2)), ALL);
      // Locked configuration, unmapped place, user address stepping
      reg_wr(`CMR_OFS_TEF_CFG, 32'h0);
      reg_rd(`CMR_OFS_TEF_CFG, 32'h21, 32'h3f);
      reg_rd(12'h0f0, 32'h0, ALL);
      reg_wr(`CMR_OFS_FIFO_UA + 12'h004, 32'h0);
      reg_rd(`CMR_OFS_FIFO_UA + 12'h004, 32'h43c, ALL);
      reg_wr(`CMR_OFS_FIFO_UA + 12'h004, 32'h0);
      reg_rd(`CMR_OFS_FIFO_UA + 12'h004, 32'h428, ALL);
      // Queue object and fetches with and without gateway mode
      reg_wr(12'h418, 32'h2abc_1234);
      reg_wr(12'h41c, 32'h0000_aad8);
      reg_wr(12'h420, 32'h0403_0201);
      eng_u.set_passive(1'b1);
      tx_chk(5'h01, 32'haad8, 32'hffff, 1'b0);
      reg_wr(`CMR_OFS_CTRL, 32'he);
      tx_chk(5'h01, 32'haad8, 32'hffff, 1'b1);
      eng_u.set_passive(1'b0);
      tx_chk(5'h01, 32'haad8, 32'hffff, 1'b0);
      tx_chk(5'h02, 32'h0403_0201, ALL, 1'b0);
      // Transmit event entry
      eng_u.req(4'h8, 5'h00, 5'h00, 5'h00, 30'h0, 9'h0, 5'h0, 32'h1234_5678);
      wait_idle;
      reg_rd(12'h400, 32'h2abc_1234, 32'h3fff_ffff);
      reg_rd(12'h404, 32'haad8, 32'hffff);
      reg_rd(12'h408, 32'h1234_5678, ALL);
      reg_rd(`CMR_OFS_TEF_UA, 32'h40c, ALL);
      // Receive with and without timestamp
      eng_u.req(4'h1, 5'h01, 5'h01, 5'h00, 30'h3234_5678, 9'h1c8, 5'h15, 32'hdead_beef);
      wait_idle;
      eng_u.req(4'h2, 5'h01, 5'h01, 5'h01, 30'h0, 9'h0, 5'h0, 32'h0b0a_0908);
      reg_rd(12'h43c, 32'h3234_5678, 32'h3fff_ffff);
      reg_rd(12'h440, 32'h0000_a9c8, 32'hf9ff);
      reg_rd(12'h444, 32'hdead_beef, ALL);
      reg_rd(12'h44c, 32'h0b0a_0908, ALL);
      eng_u.req(4'h1, 5'h02, 5'h00, 5'h00, 30'h0000_07ff, 9'h008, 5'h03, 32'h5555_aaaa);
      wait_idle;
      eng_u.req(4'h2, 5'h02, 5'h00, 5'h00, 30'h0, 9'h0, 5'h0, 32'h1357_9bdf);
      reg_rd(12'h458, 32'h1357_9bdf, ALL);
      // Injected parity: one bad parity bit, one bad data bit, two bad bits
      for (m = 0; m < 3; m++)
      begin
         reg_wr(`CMR_OFS_ECC_CTRL, e_par[m]);
         reg_wr(12'h590, e_dat[m]);
         reg_rd(12'h592, e_dat[m], ALL);
         reg_wr(`CMR_OFS_ECC_CTRL, 32'h1);
         reg_rd(12'h590, e_exp[m], ALL);
         reg_rd(`CMR_OFS_ECC_STAT, e_sta[m], 32'h01ff_0003);
         reg_wr(`CMR_OFS_ECC_STAT, 32'h3);
      end
      tally_and_finish;
   end
endmodule
`default_nettype wire
